/* File: rtl/pms_pkg.sv */
package pms_pkg;
    // ==========================================
    // sizes and timing
    localparam int          CLK_MHZ          = 10;
    localparam int          FUSE_TIME_US     = 50;
    localparam int          FUSE_CYCLES      = FUSE_TIME_US * CLK_MHZ;
    localparam int          CNT_W            = 16;
    localparam logic [15:0] CNT_RESET        = 16'h0000;

    // ==========================================
    // device operating states, one-hot
    typedef enum logic [5:0] {
        PMS_RESET  = 6'h01,
        PMS_UVLO   = 6'h02,
        PMS_FUSE   = 6'h04,
        PMS_NORMAL = 6'h08,
        PMS_LOWPWR = 6'h10,
        PMS_POLL   = 6'h20
    } pms_state_e;

    // falling-edge wake sources from the pins
    typedef struct packed {
        logic wake_pin;
        logic int_pin;
        logic cs_pin;
    } pms_pin_wake_s;

    // fault inputs sampled in normal mode
    typedef struct packed {
        logic overvoltage;
        logic overtemperature_fault;
        logic thermal_warning;
        logic serial_error;
        logic hash_error;
    } pms_fault_s;
endpackage

/* File: rtl/pms_sequencer.sv */
`timescale 1ns/100ps
module pms_sequencer #(
    parameter int N_CH        = 22,
    parameter int POLL_WINDOW = 16
) (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   por_i,
    input  wire logic                   undervoltage_i,
    input  wire logic                   io_supply_ok_i,
    input  wire logic                   enter_lowpwr_cmd_i,
    input  wire logic                   wake_pin_wake_en_i,
    input  wire pms_pkg::pms_pin_wake_s pin_level_i,
    input  wire logic                   int_timer_expire_i,
    input  wire logic                   poll_timer_expire_i,
    input  wire logic [N_CH-1:0]        above_threshold_i,
    input  wire logic [N_CH-1:0]        battery_switch_config_i,
    input  wire logic [N_CH-1:0]        wake_en_i,
    input  wire logic [N_CH-1:0]        comparator_only_i,
    input  wire logic [N_CH-1:0]        thermal_limit_i,
    input  wire logic                   thermal_cool_i,
    input  wire logic                   thermal_warn_i,
    input  wire pms_pkg::pms_fault_s    fault_i,
    input  wire logic                   fault_clear_i,
    output logic [5:0]                  state_o,
    output logic                        osc_enable_o,
    output logic                        fast_osc_o,
    output logic                        serial_enable_o,
    output logic                        sources_on_o,
    output logic                        wake_pin_oe_o,
    output logic                        wake_pin_o,
    output logic                        interrupt_o,
    output logic                        wake_report_o,
    output logic                        first_word_invalid_o,
    output logic [N_CH-1:0]             switch_closed_o,
    output logic [N_CH-1:0]             poll_active_o,
    output pms_pkg::pms_fault_s         fault_flags_o,
    output logic                        thermal_limit_fault_o,
    output logic                        min_current_o,
    output logic                        thermal_warn_o
);
    // ==========================================
    // state register and timers
    pms_pkg::pms_state_e  state, next_state;
    logic [15:0]          cnt, next_cnt;
    pms_pkg::pms_pin_wake_s pin_prev, next_pin_prev;
    logic [N_CH-1:0]      closed_at_entry, next_closed_at_entry;
    logic [N_CH-1:0]      poll_mask, next_poll_mask;
    logic [N_CH-1:0]      closed_now;
    logic                 pin_edge, change_wake, cmp_wake, any_wake_en;
    logic                 next_interrupt, next_wake_report, next_first_invalid;
    logic                 cs_edge;

    // open/closed decode per channel
    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_decode
            assign closed_now[g] = above_threshold_i[g] ^ ~battery_switch_config_i[g];
        end
    endgenerate

    // wake conditions
    always_comb begin
        next_pin_prev = pin_level_i;
        pin_edge = (pin_prev.wake_pin & ~pin_level_i.wake_pin & wake_pin_wake_en_i)
                 | (pin_prev.int_pin & ~pin_level_i.int_pin)
                 | (pin_prev.cs_pin & ~pin_level_i.cs_pin);
        cs_edge = pin_prev.cs_pin & ~pin_level_i.cs_pin;
        any_wake_en = |wake_en_i;
        cmp_wake = |(wake_en_i & comparator_only_i & (closed_now ^ closed_at_entry));
        change_wake = |(wake_en_i & poll_mask & (closed_now ^ closed_at_entry));
    end

    // ==========================================
    // operating sequence
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_closed_at_entry = closed_at_entry;
        next_poll_mask = poll_mask;
        next_interrupt = 1'b0;
        next_wake_report = wake_report_o;
        next_first_invalid = first_word_invalid_o;
        unique case (state)
            pms_pkg::PMS_RESET: begin
                if (!por_i) next_state = pms_pkg::PMS_UVLO;
            end
            pms_pkg::PMS_UVLO: begin
                if (!undervoltage_i) begin
                    next_state = pms_pkg::PMS_FUSE;
                    next_cnt = 16'(pms_pkg::FUSE_CYCLES - 1);
                end
            end
            pms_pkg::PMS_FUSE: begin
                if (undervoltage_i) next_state = pms_pkg::PMS_UVLO;
                else if (cnt == pms_pkg::CNT_RESET) next_state = pms_pkg::PMS_NORMAL;
                else next_cnt = cnt - 16'h0001;
            end
            pms_pkg::PMS_NORMAL: begin
                if (undervoltage_i) next_state = pms_pkg::PMS_UVLO;
                else if (enter_lowpwr_cmd_i) begin
                    next_state = pms_pkg::PMS_LOWPWR;
                    next_closed_at_entry = closed_now;
                    next_poll_mask = wake_en_i & ~comparator_only_i;
                    next_wake_report = 1'b0;
                end else if (pin_level_i.cs_pin) next_first_invalid = 1'b0;
            end
            pms_pkg::PMS_LOWPWR: begin
                if (int_timer_expire_i) begin
                    next_state = pms_pkg::PMS_NORMAL;
                    next_interrupt = 1'b1;
                end else if (cmp_wake) begin
                    next_state = pms_pkg::PMS_NORMAL;
                    next_interrupt = 1'b1;
                end else if (pin_edge && io_supply_ok_i) begin
                    next_state = pms_pkg::PMS_NORMAL;
                    next_wake_report = 1'b1;
                    next_interrupt = 1'b1;
                    next_first_invalid = cs_edge;
                end else if (poll_timer_expire_i && any_wake_en && !undervoltage_i) begin
                    next_state = pms_pkg::PMS_POLL;
                    next_cnt = 16'(POLL_WINDOW - 1);
                end
            end
            pms_pkg::PMS_POLL: begin
                if (int_timer_expire_i || cmp_wake) begin
                    next_state = pms_pkg::PMS_NORMAL;
                    next_interrupt = 1'b1;
                end else if (pin_edge && io_supply_ok_i) begin
                    next_state = pms_pkg::PMS_NORMAL;
                    next_wake_report = 1'b1;
                    next_interrupt = 1'b1;
                    next_first_invalid = cs_edge;
                end else if (cnt == pms_pkg::CNT_RESET) begin
                    if (change_wake) begin
                        next_state = pms_pkg::PMS_NORMAL;
                        next_wake_report = 1'b1;
                        next_interrupt = 1'b1;
                    end else begin
                        next_state = pms_pkg::PMS_LOWPWR;
                        next_poll_mask = poll_mask & (closed_at_entry | closed_now);
                    end
                end else if (!undervoltage_i) next_cnt = cnt - 16'h0001;
            end
            default: next_state = pms_pkg::PMS_RESET;
        endcase
        if (por_i) next_state = pms_pkg::PMS_RESET;
    end

    // register the sequence; settings are never touched here, so they persist
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= pms_pkg::PMS_RESET;
            cnt <= pms_pkg::CNT_RESET;
            pin_prev <= '1;
            closed_at_entry <= '0;
            poll_mask <= '0;
            interrupt_o <= 1'b0;
            wake_report_o <= 1'b0;
            first_word_invalid_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            pin_prev <= next_pin_prev;
            closed_at_entry <= next_closed_at_entry;
            poll_mask <= next_poll_mask;
            interrupt_o <= next_interrupt;
            wake_report_o <= next_wake_report;
            first_word_invalid_o <= next_first_invalid;
        end
    end

    // ==========================================
    // mode outputs derived from the next state so they leave a flip-flop aligned with state; fault and switch flags use the current state
    pms_pkg::pms_fault_s next_faults;
    logic next_limit_hit, next_mincur;
    logic [N_CH-1:0] next_switch, next_poll_act;
    always_comb begin
        next_faults = fault_flags_o;
        // capture only in normal mode; low-power faults are never seen
        if (state == pms_pkg::PMS_NORMAL) begin
            if (fault_clear_i) next_faults = '0;
            next_faults = next_faults | fault_i;
        end
        next_limit_hit = |thermal_limit_i;
        next_mincur = next_limit_hit | (min_current_o & ~thermal_cool_i);
        next_switch = (state == pms_pkg::PMS_NORMAL) ? closed_now : switch_closed_o;
        next_poll_act = (next_state == pms_pkg::PMS_POLL) ? poll_mask : '0;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_o <= pms_pkg::PMS_RESET;
            osc_enable_o <= 1'b0;
            fast_osc_o <= 1'b0;
            serial_enable_o <= 1'b0;
            sources_on_o <= 1'b0;
            wake_pin_oe_o <= 1'b0;
            wake_pin_o <= 1'b0;
            fault_flags_o <= '0;
            thermal_limit_fault_o <= 1'b0;
            min_current_o <= 1'b0;
            thermal_warn_o <= 1'b0;
            switch_closed_o <= '0;
            poll_active_o <= '0;
        end else begin
            state_o <= next_state;
            osc_enable_o <= (next_state != pms_pkg::PMS_RESET);
            fast_osc_o <= next_state inside {pms_pkg::PMS_UVLO, pms_pkg::PMS_FUSE,
                                             pms_pkg::PMS_NORMAL};
            serial_enable_o <= (next_state == pms_pkg::PMS_NORMAL);
            sources_on_o <= next_state inside {pms_pkg::PMS_NORMAL, pms_pkg::PMS_POLL};
            wake_pin_oe_o <= (next_state == pms_pkg::PMS_NORMAL);
            wake_pin_o <= 1'b0;
            fault_flags_o <= next_faults;
            thermal_limit_fault_o <= next_limit_hit;
            min_current_o <= next_mincur;
            thermal_warn_o <= thermal_warn_i;
            switch_closed_o <= next_switch;
            poll_active_o <= next_poll_act;
        end
    end

    // ==========================================
    // checks
    sequence s_lowpwr_cmd;
        state == pms_pkg::PMS_NORMAL && enter_lowpwr_cmd_i && !undervoltage_i && !por_i;
    endsequence

    lowpwr_entry_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == pms_pkg::PMS_NORMAL && next_state == pms_pkg::PMS_LOWPWR)
        |-> enter_lowpwr_cmd_i) else $error("low power entered without command");
    lowpwr_cmd_a: assert property (@(posedge clk_i) disable iff (reset_i)
        s_lowpwr_cmd |=> state == pms_pkg::PMS_LOWPWR) else $error("command not obeyed");
    fuse_time_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == pms_pkg::PMS_UVLO && next_state == pms_pkg::PMS_FUSE)
        |=> cnt == 16'(pms_pkg::FUSE_CYCLES - 1)) else $error("fuse time wrong");
    wake_pin_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state == pms_pkg::PMS_NORMAL |=> wake_pin_oe_o || state != pms_pkg::PMS_NORMAL)
        else $error("wake pin not driven in normal");
    timer_prio_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == pms_pkg::PMS_LOWPWR && int_timer_expire_i && !por_i)
        |=> state == pms_pkg::PMS_NORMAL && interrupt_o) else $error("timer lost");
    io_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == pms_pkg::PMS_LOWPWR && !io_supply_ok_i && !int_timer_expire_i
         && !cmp_wake && !por_i) |=> state != pms_pkg::PMS_NORMAL)
        else $error("woke with io supply low");
    no_poll_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == pms_pkg::PMS_LOWPWR && !any_wake_en) |=> state != pms_pkg::PMS_POLL)
        else $error("polled with no wake enables");
    uv_pause_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == pms_pkg::PMS_POLL && undervoltage_i && next_state == pms_pkg::PMS_POLL)
        |=> $stable(cnt)) else $error("poll ran in undervoltage");
    fault_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state inside {pms_pkg::PMS_LOWPWR, pms_pkg::PMS_POLL} |=> $stable(fault_flags_o))
        else $error("fault captured in low power");

    // outputs follow the state register, so each state shows its own output set
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state == pms_pkg::PMS_RESET |-> !osc_enable_o && !sources_on_o && !serial_enable_o)
        else $error("activity while in reset");
    lockout_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state == pms_pkg::PMS_UVLO |-> !serial_enable_o && !sources_on_o)
        else $error("serial or sources on in lockout");
    osc_on_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state == pms_pkg::PMS_UVLO |-> osc_enable_o && fast_osc_o)
        else $error("oscillators off in lockout");
    fast_osc_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state inside {pms_pkg::PMS_LOWPWR, pms_pkg::PMS_POLL} |-> !fast_osc_o)
        else $error("fast clock running in low power");
    fault_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state == pms_pkg::PMS_NORMAL |=> (fault_flags_o & $past(fault_i)) == $past(fault_i))
        else $error("fault not flagged in normal");
    min_current_a: assert property (@(posedge clk_i) disable iff (reset_i)
        |thermal_limit_i |=> min_current_o && thermal_limit_fault_o)
        else $error("current not cut at thermal limit");

    // poll steps: the window opens, runs out, and then sleeps or wakes
    sequence s_poll_start;
        state == pms_pkg::PMS_LOWPWR && next_state == pms_pkg::PMS_POLL;
    endsequence

    // a window that runs out with no higher-priority wake in the same cycle
    sequence s_poll_end;
        state == pms_pkg::PMS_POLL && cnt == pms_pkg::CNT_RESET && !int_timer_expire_i
        && !cmp_wake && !(pin_edge && io_supply_ok_i) && !por_i;
    endsequence

    poll_len_a: assert property (@(posedge clk_i) disable iff (reset_i)
        s_poll_start |=> cnt == 16'(POLL_WINDOW - 1)) else $error("poll window wrong");
    poll_sleep_a: assert property (@(posedge clk_i) disable iff (reset_i)
        s_poll_end ##0 !change_wake |=> state == pms_pkg::PMS_LOWPWR)
        else $error("poll did not return to sleep");
    poll_wake_a: assert property (@(posedge clk_i) disable iff (reset_i)
        s_poll_end ##0 change_wake |=> state == pms_pkg::PMS_NORMAL && wake_report_o)
        else $error("poll change did not wake");
    // an input open at entry and open again at poll end must leave the mask
    poll_drop_a: assert property (@(posedge clk_i) disable iff (reset_i)
        s_poll_end ##0 !change_wake
        |=> (poll_mask & ~closed_at_entry & ~$past(closed_now)) == '0)
        else $error("open input still polled");
endmodule

/* File: sim/pms_host_model.sv */
`timescale 1ns/100ps
// ==========================================
// host side: sleep command and open-drain pins
module pms_host_model (
    input  wire logic              clk_i,
    input  wire logic [5:0]        state_i,
    input  wire logic              sleep_req_i,
    input  wire logic [2:0]        pin_low_i,
    output logic                   enter_lowpwr_cmd_o,
    output pms_pkg::pms_pin_wake_s pin_level_o
);
    // the port only listens in normal mode, so the command is only sent there
    always @(negedge clk_i) begin
        enter_lowpwr_cmd_o <= sleep_req_i && (state_i == 6'h08);
        // a released pin is pulled up, never left at its last level
        pin_level_o <= pms_pkg::pms_pin_wake_s'(~pin_low_i);
    end
endmodule

/* File: sim/power_mode_sequencer_tb_top.sv */
`timescale 1ns/100ps
module power_mode_sequencer_tb_top;
    // ==========================================
    // signals
    localparam int NC = 4;
    localparam int PW = 4;
    logic clk_i = 1'b0, reset_i = 1'b1, por_i = 1'b0, low_batt = 1'b1, io_ok = 1'b1;
    logic sleep_req = 1'b0, wake_en_pin = 1'b1, int_exp = 1'b0, poll_exp = 1'b0;
    logic cool = 1'b0, warn = 1'b0, fclr = 1'b0, cmd, wfi, wrep, irq, wpo, wpoe;
    logic [2:0] pin_low = 3'h0;
    logic [NC-1:0] above = 4'h0, batt = 4'h0, wen = 4'h0, conly = 4'h0, lim_cells = 4'h0;
    logic [NC-1:0] closed, pact;
    logic [5:0] state_o;
    logic osc, fosc, ser, src, tfault, minc, twarn;
    pms_pkg::pms_pin_wake_s pins;
    pms_pkg::pms_fault_s fault_i = 5'h00, flags;
    int fail_count = 0, n_compared = 0;

    always #50 clk_i = ~clk_i;

    pms_host_model u_host (.clk_i(clk_i), .state_i(state_o), .sleep_req_i(sleep_req),
        .pin_low_i(pin_low), .enter_lowpwr_cmd_o(cmd), .pin_level_o(pins));

    pms_sequencer #(.N_CH(NC), .POLL_WINDOW(PW)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
        .por_i(por_i), .undervoltage_i(low_batt), .io_supply_ok_i(io_ok),
        .enter_lowpwr_cmd_i(cmd), .wake_pin_wake_en_i(wake_en_pin), .pin_level_i(pins),
        .int_timer_expire_i(int_exp), .poll_timer_expire_i(poll_exp),
        .above_threshold_i(above), .battery_switch_config_i(batt), .wake_en_i(wen),
        .comparator_only_i(conly), .thermal_limit_i(lim_cells), .thermal_cool_i(cool),
        .thermal_warn_i(warn), .fault_i(fault_i), .fault_clear_i(fclr),
        .state_o(state_o), .osc_enable_o(osc), .fast_osc_o(fosc), .serial_enable_o(ser),
        .sources_on_o(src), .wake_pin_oe_o(wpoe), .wake_pin_o(wpo), .interrupt_o(irq),
        .wake_report_o(wrep), .first_word_invalid_o(wfi), .switch_closed_o(closed),
        .poll_active_o(pact), .fault_flags_o(flags), .thermal_limit_fault_o(tfault),
        .min_current_o(minc), .thermal_warn_o(twarn));

    // ==========================================
    // access tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // bounded wait, so a stuck state machine shows up as a mismatch
    task automatic wait_st(input logic [5:0] exp, input int lim);
        for (int i = 0; i < lim && state_o !== exp; i++) cyc(1);
        chk("state", state_o, exp);
    endtask
    task automatic sleep();
        sleep_req <= 1'b1;
        cyc(1);
        sleep_req <= 1'b0;
        wait_st(6'h10, 4);
    endtask
    task automatic pulse_pins(input logic [2:0] p);
        pin_low <= p;
        cyc(2);
        pin_low <= 3'h0;
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(5000 * 100);
        fail_count++;
        test_done();
    end

    // ==========================================
    // tests
    initial begin
        cyc(20);
        chk("state", state_o, 6'h01);
        chk("osc", osc, 1'b0);
        reset_i <= 1'b0;
        wait_st(6'h02, 4);
        chk("ser", ser, 1'b0);
        chk("src", src, 1'b0);
        chk("osc", {osc, fosc}, 2'h3);
        low_batt <= 1'b0;
        wait_st(6'h04, 4);
        cyc(pms_pkg::FUSE_CYCLES - 2);
        chk("state", state_o, 6'h04);
        wait_st(6'h08, 6);
        chk("wake pin", {wpoe, wpo, ser}, 3'h5);
        // battery ch0/ch1, ground ch2/ch3, each above and below threshold
        above <= 4'h5;
        batt <= 4'h3;
        cyc(3);
        chk("closed", closed, 4'h9);
        fault_i <= 5'h1f;
        cyc(1);
        fault_i <= 5'h00;
        cyc(2);
        chk("flags", flags, 5'h1f);
        fclr <= 1'b1;
        cyc(1);
        fclr <= 1'b0;
        cyc(2);
        chk("flags", flags, 5'h00);
        lim_cells <= 4'h4;
        warn <= 1'b1;
        cyc(3);
        chk("thermal", {tfault, minc, twarn}, 3'h7);
        lim_cells <= 4'h0;
        warn <= 1'b0;
        cyc(3);
        chk("thermal", {tfault, minc, twarn}, 3'h2);
        cool <= 1'b1;
        cyc(1);
        cool <= 1'b0;
        cyc(2);
        chk("min current", minc, 1'b0);
        wen <= 4'h3;
        sleep();
        chk("lp outs", {fosc, wpoe, ser}, 3'h0);
        fault_i <= 5'h1f;
        io_ok <= 1'b0;
        pulse_pins(3'h1);
        fault_i <= 5'h00;
        cyc(4);
        chk("state", {state_o, wrep}, {6'h10, 1'b0});
        io_ok <= 1'b1;
        poll_exp <= 1'b1;
        cyc(1);
        poll_exp <= 1'b0;
        wait_st(6'h20, 3);
        chk("src", src, 1'b1);
        chk("poll act", pact, 4'h3);
        low_batt <= 1'b1;
        cyc(PW + 4);
        chk("state", state_o, 6'h20);
        low_batt <= 1'b0;
        wait_st(6'h10, PW + 4);
        poll_exp <= 1'b1;
        cyc(1);
        poll_exp <= 1'b0;
        wait_st(6'h20, 3);
        chk("poll act", pact, 4'h1);
        above[0] <= 1'b0;
        wait_st(6'h08, PW + 4);
        chk("report", {wrep, flags}, {1'b1, 5'h00});
        // each pin source in turn, cs marks the first word bad
        for (int k = 0; k < 3; k++) begin
            sleep();
            pulse_pins(3'h1 << k);
            wait_st(6'h08, 6);
            chk("pin wake", {wrep, wfi}, {1'b1, k == 0});
            cyc(2);
        end
        sleep();
        int_exp <= 1'b1;
        poll_exp <= 1'b1;
        cyc(1);
        {int_exp, poll_exp} <= 2'h0;
        wait_st(6'h08, 4);
        chk("irq", irq, 1'b1);
        sleep();
        conly <= 4'h2;
        above[1] <= 1'b1;
        wait_st(6'h08, 4);
        conly <= 4'h0;
        wen <= 4'h0;
        sleep();
        poll_exp <= 1'b1;
        above[0] <= 1'b1;
        cyc(1);
        poll_exp <= 1'b0;
        cyc(PW + 4);
        chk("state", state_o, 6'h10);
        por_i <= 1'b1;
        cyc(2);
        chk("por", {state_o, osc, src}, {6'h01, 2'h0});
        por_i <= 1'b0;
        wait_st(6'h02, 4);
        test_done();
    end
endmodule
